/* rtl/eeprom_wp_defines.svh */
// Constants for the write-protection and status block
`ifndef EEPROM_WP_DEFINES_SVH
`define EEPROM_WP_DEFINES_SVH
`define CMD_SET_LATCH 8'h06
`define CMD_CLEAR_LATCH 8'h04
`define CMD_STATUS_READ 8'h05
`define CMD_STATUS_WRITE 8'h01
`define CMD_ARRAY_WRITE 8'h02
`define SR_PIN_PROTECT_BIT 7
`define SR_BP_HI_BIT 3
`define SR_BP_LO_BIT 2
`define SR_LATCH_BIT 1
`define SR_BUSY_BIT 0
`define QUARTER_BASE 13'h1800
`define HALF_BASE 13'h1000
`define NV_RESET 3'h0
`endif

/* rtl/eeprom_wp_pkg.sv */
// Types shared by the write-protection and status block
package eeprom_wp_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD = 2'b01,
        ST_DATA = 2'b11,
        ST_DONE = 2'b10
    } link_state_t;
endpackage : eeprom_wp_pkg

/* rtl/eeprom_wp_status.sv */
// Write-protection latch, status register and array protection map
`timescale 1ns/100ps
`include "eeprom_wp_defines.svh"

module eeprom_wp_status
    import eeprom_wp_pkg::*;
#(
    parameter int ADDR_W = 13
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    input wire logic i_write_done,
    output logic o_so,
    output logic o_so_oe_n,
    output logic o_write_start,
    output logic o_array_write,
    output logic [ADDR_W-1:0] o_write_addr,
    output logic [7:0] o_status
);
    // ****************************************************************
    // Reset release and system-side state
    // ****************************************************************
    logic rst_m_r;
    logic rst_s_r;
    logic rst_n;
    logic latch_r;
    logic busy_r;
    logic pin_en_r;
    logic [1:0] bp_r;
    logic wp_m_r;
    logic wp_s_r;
    logic [7:0] status;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_m_r <= 1'b0;
            rst_s_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_s_r <= rst_m_r;
        end
    end
    assign rst_n = rst_s_r;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_m_r <= 1'b1;
            wp_s_r <= 1'b1;
        end else begin
            wp_m_r <= i_wp_n;
            wp_s_r <= wp_m_r;
        end
    end

    // Status byte as seen by the link side
    always_comb begin
        status = 8'h00;
        status[`SR_PIN_PROTECT_BIT] = pin_en_r;
        status[`SR_BP_HI_BIT] = bp_r[1];
        status[`SR_BP_LO_BIT] = bp_r[0];
        status[`SR_LATCH_BIT] = latch_r;
        status[`SR_BUSY_BIT] = busy_r;
    end
    assign o_status = status;

    // ****************************************************************
    // Link-side shifter, runs on the serial clock
    // ****************************************************************
    link_state_t lst_r;
    logic [7:0] cmd_r;
    logic [7:0] sh_r;
    logic [5:0] bits_r;
    logic [15:0] addr_r;
    logic [7:0] data_r;
    logic data_ok_r;
    logic [7:0] tx_r;
    logic [7:0] st_m_r;
    logic [7:0] st_s_r;
    logic fresh_r;
    logic frame_tgl_r;
    logic frame_clr;

    assign frame_clr = i_cs_n || !rst_n;

    // Status snapshot brought over on every rising serial clock; bits are quasi-static
    always_ff @(posedge i_sck or negedge rst_n) begin
        if (!rst_n) begin
            st_m_r <= 8'h00;
            st_s_r <= 8'h00;
        end else begin
            st_m_r <= status;
            st_s_r <= st_m_r;
        end
    end

    // Frame start flag: set while deselected, dropped by the first clock of a frame
    always_ff @(posedge i_sck or posedge frame_clr) begin
        if (frame_clr) begin
            fresh_r <= 1'b1;
        end else begin
            fresh_r <= 1'b0;
        end
    end

    // Frame state stays put after select rises, for the system side to read
    always_ff @(posedge i_sck or negedge rst_n) begin
        if (!rst_n) begin
            lst_r <= ST_IDLE;
            cmd_r <= 8'h00;
            sh_r <= 8'h00;
            bits_r <= 6'h00;
            addr_r <= 16'h0000;
            data_r <= 8'h00;
            data_ok_r <= 1'b0;
            frame_tgl_r <= 1'b0;
        end else if (fresh_r) begin
            // First clock of a frame drops whatever the last frame left
            lst_r <= ST_CMD;
            cmd_r <= 8'h00;
            sh_r <= {7'h00, i_si};
            bits_r <= 6'h01;
            addr_r <= 16'h0000;
            data_r <= 8'h00;
            data_ok_r <= 1'b0;
            frame_tgl_r <= !frame_tgl_r;
        end else begin
            sh_r <= {sh_r[6:0], i_si};
            case (lst_r)
                ST_IDLE: begin
                    lst_r <= ST_CMD;
                    bits_r <= 6'h01;
                end
                ST_CMD: begin
                    bits_r <= bits_r + 6'h01;
                    if (bits_r == 6'h07) begin
                        cmd_r <= {sh_r[6:0], i_si};
                        lst_r <= ST_DATA;
                        bits_r <= 6'h00;
                    end
                end
                ST_DATA: begin
                    bits_r <= (bits_r == 6'h3f) ? 6'h20 : bits_r + 6'h01;
                    if (bits_r < 6'h10) begin
                        addr_r <= {addr_r[14:0], i_si};
                    end
                    if (bits_r[2:0] == 3'h7) begin
                        data_r <= {sh_r[6:0], i_si};
                        data_ok_r <= 1'b1;
                    end
                end
                default: begin
                    lst_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Output shifts on the falling edge; status repeats per byte
    always_ff @(negedge i_sck or posedge frame_clr) begin
        if (frame_clr) begin
            tx_r <= 8'hff;
            o_so_oe_n <= 1'b1;
        end else if (lst_r == ST_DATA && cmd_r == `CMD_STATUS_READ) begin
            o_so_oe_n <= 1'b0;
            if (bits_r[2:0] == 3'h0) begin
                tx_r <= st_s_r;
            end else begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end else begin
            tx_r <= 8'hff;
            o_so_oe_n <= 1'b1;
        end
    end
    assign o_so = tx_r[7];

    // ****************************************************************
    // Frame end crossing: select rise captured in the system clock
    // ****************************************************************
    logic cs_m_r;
    logic cs_s_r;
    logic cs_d_r;
    logic seen_tgl_r;
    logic sel_rise;
    logic frame_end;
    logic [7:0] f_cmd;
    logic [5:0] f_bits;
    logic f_ok;
    logic exact_byte;
    logic exact_write;
    logic hw_prot;
    logic addr_prot;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_m_r <= 1'b1;
            cs_s_r <= 1'b1;
            cs_d_r <= 1'b1;
        end else begin
            cs_m_r <= i_cs_n;
            cs_s_r <= cs_m_r;
            cs_d_r <= cs_s_r;
        end
    end
    // Link registers are frozen while select is high, so reading them is safe
    assign sel_rise = cs_s_r && !cs_d_r;
    // A select pulse with no clock inside it leaves the toggle alone and runs nothing
    assign frame_end = sel_rise && (frame_tgl_r != seen_tgl_r);

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_tgl_r <= 1'b0;
        end else if (frame_end) begin
            seen_tgl_r <= frame_tgl_r;
        end
    end
    assign f_cmd = cmd_r;
    assign f_bits = bits_r;
    assign f_ok = data_ok_r;
    assign exact_byte = (lst_r == ST_DATA) && (f_bits == 6'h00);
    assign exact_write = (lst_r == ST_DATA) && f_ok && (f_bits[2:0] == 3'h0)
        && (f_bits >= 6'h18);
    assign hw_prot = !wp_s_r && pin_en_r;

    always_comb begin
        case (bp_r)
            2'b01: addr_prot = addr_r[ADDR_W-1:0] >= `QUARTER_BASE;
            2'b10: addr_prot = addr_r[ADDR_W-1:0] >= `HALF_BASE;
            2'b11: addr_prot = 1'b1;
            default: addr_prot = 1'b0;
        endcase
    end

    // ****************************************************************
    // Command execution at frame end
    // ****************************************************************
    logic start_sr;
    logic start_arr;

    // Writes start only with an idle device, a set latch and an exact frame
    assign start_sr = frame_end && !busy_r && latch_r && !hw_prot
        && f_cmd == `CMD_STATUS_WRITE && f_bits == 6'h08;
    assign start_arr = frame_end && !busy_r && latch_r && !addr_prot
        && f_cmd == `CMD_ARRAY_WRITE && exact_write;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_r <= 1'b0;
        end else if (frame_end && exact_byte && f_cmd == `CMD_SET_LATCH && !busy_r) begin
            latch_r <= 1'b1;
        end else if (frame_end && exact_byte && f_cmd == `CMD_CLEAR_LATCH && !busy_r) begin
            latch_r <= 1'b0;
        end else if (busy_r && i_write_done) begin
            latch_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (start_sr || start_arr) begin
            busy_r <= 1'b1;
        end else if (i_write_done) begin
            busy_r <= 1'b0;
        end
    end

    // Nonvolatile bits: reset value stands in for the stored copy
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            {pin_en_r, bp_r} <= `NV_RESET;
        end else if (start_sr) begin
            pin_en_r <= data_r[`SR_PIN_PROTECT_BIT];
            bp_r <= {data_r[`SR_BP_HI_BIT], data_r[`SR_BP_LO_BIT]};
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_write_start <= 1'b0;
            o_array_write <= 1'b0;
            o_write_addr <= '0;
        end else begin
            o_write_start <= start_sr || start_arr;
            o_array_write <= start_arr;
            if (start_arr) begin
                o_write_addr <= addr_r[ADDR_W-1:0];
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_latch_needed;
        @(posedge i_clk) disable iff (!rst_n)
        o_write_start |-> $past(latch_r);
    endproperty
    a_latch_needed: assert property (p_latch_needed) else $error("write without latch");

    property p_busy_follows;
        @(posedge i_clk) disable iff (!rst_n)
        $rose(busy_r) |-> o_write_start;
    endproperty
    a_busy_follows: assert property (p_busy_follows) else $error("busy without start");

    property p_no_start_busy;
        @(posedge i_clk) disable iff (!rst_n)
        o_write_start |-> !$past(busy_r);
    endproperty
    a_no_start_busy: assert property (p_no_start_busy) else $error("start during busy");

    property p_hw_blocks_sr;
        @(posedge i_clk) disable iff (!rst_n)
        (o_write_start && !o_array_write) |-> !$past(hw_prot);
    endproperty
    a_hw_blocks_sr: assert property (p_hw_blocks_sr) else $error("status write under pin");

    property p_nv_stable;
        @(posedge i_clk) disable iff (!rst_n)
        !$past(start_sr) |-> $stable({pin_en_r, bp_r});
    endproperty
    a_nv_stable: assert property (p_nv_stable) else $error("protect bits changed");

    property p_latch_clear_done;
        @(posedge i_clk) disable iff (!rst_n)
        (busy_r && i_write_done) |=> !latch_r;
    endproperty
    a_latch_clear_done: assert property (p_latch_clear_done) else $error("latch kept");

    property p_prot_map;
        @(posedge i_clk) disable iff (!rst_n)
        o_array_write |-> !(bp_r == 2'b11);
    endproperty
    a_prot_map: assert property (p_prot_map) else $error("protected write");

    property p_status_map;
        @(posedge i_clk) disable iff (!rst_n)
        o_status[1:0] == {latch_r, busy_r} && o_status[6:4] == 3'h0;
    endproperty
    a_status_map: assert property (p_status_map) else $error("status layout");
endmodule : eeprom_wp_status

/* test/spi_host_model.sv */
// SPI host model that drives whole frames onto the serial link
`timescale 1ns/100ps
module spi_host_model (
    input wire logic i_so,
    input wire logic i_so_oe_n,
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si
);
    logic so_last;
    logic [15:0] rx;
    // A released output reads as the inverse of its last level
    wire logic so_bus = i_so_oe_n ? ~so_last : i_so;
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
        so_last = 1'b0;
        rx = 16'h0000;
    end
    always @(posedge o_sck) begin
        so_last <= so_bus;
    end
    // Clock stands low outside frames; select rises after the last bit
    task automatic frame(input logic [31:0] v, input int n);
        o_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #3 o_sck = 1'b0;
            o_si = v[i];
            #3 o_sck = 1'b1;
            rx = {rx[14:0], so_bus};
        end
        #3 o_sck = 1'b0;
        #3 o_cs_n = 1'b1;
    endtask : frame
endmodule : spi_host_model

/* test/tb_eeprom_wp_status.sv */
// Self-checking bench for the write-protection and status block
`timescale 1ns/100ps
`include "eeprom_wp_defines.svh"
module tb_eeprom_wp_status;
    logic i_clk, i_rst_n, i_wp_n, i_write_done, last_arr, ok;
    wire logic sck, cs_n, si, so, so_oe_n, wstart, awr;
    wire logic [12:0] waddr;
    wire logic [7:0] status;
    logic [12:0] last_addr, a;
    logic [12:0] addrs [3] = '{13'h0fff, 13'h17ff, 13'h1800};
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    int starts = 0;
    int n;
    eeprom_wp_status #(.ADDR_W(13)) u_eeprom_wp_status (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_wp_n(i_wp_n), .i_write_done(i_write_done),
        .o_so(so), .o_so_oe_n(so_oe_n), .o_write_start(wstart), .o_array_write(awr),
        .o_write_addr(waddr), .o_status(status));
    spi_host_model u_spi_host_model (.i_so(so), .i_so_oe_n(so_oe_n), .o_sck(sck),
        .o_cs_n(cs_n), .o_si(si));
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (wstart === 1'b1) begin
            starts <= starts + 1;
            last_arr <= awr;
            last_addr <= waddr;
        end
        if (cyc == 20000) begin
            num_errors++;
            results();
        end
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic [31:0] v, input int bits);
        u_spi_host_model.frame(v, bits);
        repeat (8) @(negedge i_clk);
    endtask : xfer
    // Write timer ends the internal cycle
    task automatic done();
        @(negedge i_clk) i_write_done = 1'b1;
        @(negedge i_clk) i_write_done = 1'b0;
        repeat (3) @(negedge i_clk);
    endtask : done
    task automatic results();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        i_rst_n = 1'b0;
        i_wp_n = 1'b1;
        i_write_done = 1'b0;
        repeat (12) @(negedge i_clk);
        i_rst_n = 1'b1;
        repeat (4) @(negedge i_clk);
        chk({so_oe_n, status}, 16'h0100);
        xfer({`CMD_STATUS_WRITE, 8'hff}, 16);
        chk({16'(starts) << 8} | status, 16'h0000);
        xfer(`CMD_SET_LATCH, 8);
        chk(status, 8'h02);
        xfer(`CMD_CLEAR_LATCH, 8);
        chk(status, 8'h00);
        xfer({`CMD_SET_LATCH, 8'h00}, 16);
        chk(status, 8'h00);
        xfer(`CMD_SET_LATCH, 8);
        xfer({`CMD_STATUS_WRITE, 8'hff}, 16);
        chk({16'(starts) << 8} | last_arr, 16'h0100);
        i_wp_n = 1'b0;
        chk(status & 8'h8d, 8'h8d);
        xfer({`CMD_STATUS_READ, 16'h0000}, 24);
        chk(u_spi_host_model.rx & 16'h8d8d, 16'h8d8d);
        xfer({`CMD_ARRAY_WRITE, 16'h0000, 8'h55}, 32);
        chk(16'(starts), 16'h0001);
        done();
        chk({so_oe_n, status}, 16'h018c);
        xfer(`CMD_SET_LATCH, 8);
        xfer({`CMD_STATUS_WRITE, 8'h00}, 16);
        chk({16'(starts) << 8} | status, 16'h018e);
        i_wp_n = 1'b1;
        xfer({`CMD_STATUS_WRITE, 8'h00}, 16);
        done();
        i_wp_n = 1'b0;
        chk(status, 8'h00);
        for (int bp = 3; bp >= 0; bp--) begin
            xfer(`CMD_SET_LATCH, 8);
            xfer({`CMD_STATUS_WRITE, 4'h0, bp[1:0], 2'b00}, 16);
            done();
            chk(status, {4'h0, bp[1:0], 2'b00});
            for (int k = 0; k < 3; k++) begin
                a = addrs[k];
                n = starts;
                ok = !(bp == 3 || (bp == 2 && a >= 13'h1000) || (bp == 1 && a >= 13'h1800));
                xfer(`CMD_SET_LATCH, 8);
                xfer({`CMD_ARRAY_WRITE, 3'b000, a, 8'ha5}, 32);
                chk(16'(starts - n), {15'h0000, ok});
                if (ok) begin
                    chk({last_arr, 2'b00, last_addr}, {3'b100, a});
                    done();
                    chk(status, {4'h0, bp[1:0], 2'b00});
                end
            end
        end
        n = starts;
        xfer(`CMD_SET_LATCH, 8);
        xfer({1'b0, `CMD_ARRAY_WRITE, 16'h0010, 7'h52}, 31);
        chk({16'(starts - n) << 8} | status, 16'h0002);
        results();
    end
endmodule : tb_eeprom_wp_status
